// File: logic/rmc_regs.svh
/*
 * register indices, field positions, reset values and masks of the
 * receive monitor control bank.
 * assumes a 32-bit register bus: byte address is four times the index.
 */
`ifndef RMC_REGS_SVH
`define RMC_REGS_SVH

// register indices (byte address = index * 4)
`define RMC_IDX_SYNC     10'h100
`define RMC_IDX_FD       10'h104
`define RMC_IDX_COARSE   10'h105
`define RMC_IDX_FUP_LO   10'h106
`define RMC_IDX_FUP_HI   10'h107
`define RMC_IDX_FLO_LO   10'h108
`define RMC_IDX_FLO_HI   10'h109
`define RMC_IDX_DCB_LO   10'h10f
`define RMC_IDX_DCB_HI   10'h110
`define RMC_IDX_SER      10'h111
`define RMC_IDX_MON      10'h112
`define RMC_IDX_PER0     10'h113
`define RMC_IDX_PER1     10'h114
`define RMC_IDX_PER2     10'h115
`define RMC_IDX_RESA0    10'h116
`define RMC_IDX_RESA1    10'h117
`define RMC_IDX_RESA2    10'h118
`define RMC_IDX_RESB0    10'h119
`define RMC_IDX_RESB1    10'h11a
`define RMC_IDX_RESB2    10'h11b
// channel a dc value pair
`define RMC_IDX_DCA_LO   10'h10d
`define RMC_IDX_DCA_HI   10'h10e

// sync control fields
`define RMC_SYNC_MASTER  0
`define RMC_SYNC_DIV     1
`define RMC_SYNC_NEXT    2
`define RMC_SYNC_MON     7

// writable bit masks, open bits read zero
`define RMC_MASK_SYNC    8'h87
`define RMC_MASK_FD      8'h0f
`define RMC_MASK_COARSE  8'h07
`define RMC_MASK_FHI     8'h1f
`define RMC_MASK_SER     8'h7f
`define RMC_MASK_MON     8'h8f

// reset values
`define RMC_RST_ZERO     8'h00
`define RMC_RST_SER      8'h04
`define RMC_RST_PER0     8'h40

// axi response codes
`define RMC_RESP_OKAY    2'b00
`define RMC_RESP_SLVERR  2'b10

`endif

// File: logic/rmc_pkg.sv
/*
 * types of the receive monitor control bank.
 * assumes rmc_regs.svh sits beside it for the numeric constants.
 */
package rmc_pkg;

  // monitor configuration handed to the monitor datapath
  typedef struct packed {
    logic        enable;     // monitor on
    logic        complex_en; // complex power mode
    logic        ms_sel;     // 0 rms, 1 ms
    logic [1:0]  mode;       // result content select
    logic [23:0] period;     // cycles per measurement
  } rmc_mon_cfg_t;

  // monitor serial port configuration
  typedef struct packed {
    logic       rms_out_en;  // magnitude word on port
    logic       peak_out_en; // peak word on port
    logic       thr_out_en;  // crossing word on port
    logic [1:0] clk_div;     // serial clock ratio code
    logic       sleep;       // clock parks low when idle
    logic       port_en;     // serial output on
  } rmc_ser_cfg_t;

  // fast detect configuration
  typedef struct packed {
    logic [2:0] mode;        // pin report mode
    logic [2:0] coarse;      // coarse upper level
  } rmc_fd_cfg_t;

endpackage : rmc_pkg

// File: logic/rmc_top.sv
/*
 * receive monitor control register bank: axi4-lite slave, sync gating,
 * fast detect pin control, fine threshold flags, monitor serial clock.
 * assumes magnitudes, dc values and results come from logic on aclk;
 * only the sync pin is asynchronous.
 */
// Chosen here: the AXI4-Lite slave port.
// Functional notes
// - monitor sync passes when bits 7,0 set
// - divider sync passes when bits 1,0 set
// - next-sync-only: first pulse, then clear bit 1
// - master sync low blocks all sync
// - fast detect disabled puts pins high-z
// - interleaved: float only when both channels off
// - fast detect mode field bits 3:1
// - coarse upper threshold field bits 2:0
// - magnitude above fine upper sets flag
// - magnitude below fine lower sets flag
// - fine upper split low byte, 12:8
// - fine lower split low byte, 12:8
// - 24-bit period, reset 0x40
// - 20-bit read-only results, three bytes
// - channel b dc value 14-bit read-only
// - serial clock divide 2, 4, 8
// - power select rms or ms
// - monitor mode selects result content
`timescale 1ns/10ps
`include "rmc_regs.svh"

module rmc_top #(
  parameter int MAG_W = 10,  // sample magnitude width
  parameter int THR_W = 13,  // fine threshold width
  parameter int FD_W  = 2    // fast detect pins
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sync_pin,
  output logic                   mon_sync_pulse,
  output logic                   div_sync_pulse,
  input  wire logic [MAG_W-1:0]  sample_mag,
  output logic                   precise_upper_flag,
  output logic                   precise_lower_flag,
  input  wire logic              diff_interleave,
  input  wire logic              chan_a_on,
  input  wire logic              chan_b_on,
  input  wire logic [FD_W-1:0]   fd_a_in,
  input  wire logic [FD_W-1:0]   fd_b_in,
  output logic [FD_W-1:0]        fd_pin_o,
  output logic [FD_W-1:0]        fd_pin_oe,
  output rmc_pkg::rmc_fd_cfg_t   fd_cfg,
  input  wire logic [13:0]       dc_value_a,
  input  wire logic [13:0]       dc_value_b,
  input  wire logic [19:0]       result_a,
  input  wire logic [19:0]       result_b,
  input  wire logic              mon_data_pending,
  output rmc_pkg::rmc_mon_cfg_t  mon_cfg,
  output rmc_pkg::rmc_ser_cfg_t  ser_cfg,
  output logic                   monitor_serial_clock
);
  import rmc_pkg::*;

  // refuse widths the comparators cannot serve
  if (MAG_W > THR_W || MAG_W < 1 || FD_W < 1) begin : g_chk
    $error("rmc_top: bad width parameters");
  end

  // stored registers, open bits kept zero
  logic [7:0] sync_reg;    // sync gating control
  logic [7:0] fd_reg;      // fast detect control
  logic [7:0] coarse_reg;  // coarse upper level
  logic [7:0] fup_lo_reg;  // fine upper low byte
  logic [7:0] fup_hi_reg;  // fine upper high bits
  logic [7:0] flo_lo_reg;  // fine lower low byte
  logic [7:0] flo_hi_reg;  // fine lower high bits
  logic [7:0] ser_reg;     // serial port control
  logic [7:0] mon_reg;     // monitor control
  logic [7:0] per_reg [3]; // period bytes, lsb first

  // bus state
  logic       aw_held_reg; // write address captured
  logic       w_held_reg;  // write data captured
  logic [9:0] aw_idx_reg;  // captured write index
  logic [7:0] wbyte_reg;   // captured low data byte
  logic       wlane_reg;   // low lane strobe
  logic       do_write;    // both halves present

  // sync path
  logic       sync_ff1;    // first synchroniser stage
  logic       sync_ff2;    // second stage
  logic       sync_ff3;    // edge history
  logic       sync_edge;   // rising edge of pin
  logic       div_fire;    // divider pulse this cycle

  // serial clock divider
  logic [1:0] sclk_cnt_reg; // half period counter

  // write index decode, used by both write and read checks
  function automatic logic idx_known(input logic [9:0] idx);
    idx_known = (idx >= `RMC_IDX_SYNC && idx <= `RMC_IDX_FLO_HI
                 && idx != 10'h101 && idx != 10'h102 && idx != 10'h103)
             || (idx >= `RMC_IDX_DCA_LO && idx <= `RMC_IDX_RESB2);
  endfunction

  // half period in cycles, minus one, for a divide code
  function automatic logic [1:0] half_last(input logic [1:0] code);
    if (code == 2'b11) begin
      half_last = 2'd3;
    end else if (code == 2'b10) begin
      half_last = 2'd1;
    end else begin
      half_last = 2'd0;
    end
  endfunction

  // read data for an index, open bits zero
  function automatic logic [7:0] rd_byte(input logic [9:0] idx);
    if (idx == `RMC_IDX_SYNC) begin
      rd_byte = sync_reg;
    end else if (idx == `RMC_IDX_FD) begin
      rd_byte = fd_reg;
    end else if (idx == `RMC_IDX_COARSE) begin
      rd_byte = coarse_reg;
    end else if (idx == `RMC_IDX_FUP_LO) begin
      rd_byte = fup_lo_reg;
    end else if (idx == `RMC_IDX_FUP_HI) begin
      rd_byte = fup_hi_reg;
    end else if (idx == `RMC_IDX_FLO_LO) begin
      rd_byte = flo_lo_reg;
    end else if (idx == `RMC_IDX_FLO_HI) begin
      rd_byte = flo_hi_reg;
    end else if (idx == `RMC_IDX_DCA_LO) begin
      rd_byte = dc_value_a[7:0];
    end else if (idx == `RMC_IDX_DCA_HI) begin
      rd_byte = {2'b00, dc_value_a[13:8]};
    end else if (idx == `RMC_IDX_DCB_LO) begin
      rd_byte = dc_value_b[7:0];
    end else if (idx == `RMC_IDX_DCB_HI) begin
      rd_byte = {2'b00, dc_value_b[13:8]};
    end else if (idx == `RMC_IDX_SER) begin
      rd_byte = ser_reg;
    end else if (idx == `RMC_IDX_MON) begin
      rd_byte = mon_reg;
    end else if (idx == `RMC_IDX_PER0) begin
      rd_byte = per_reg[0];
    end else if (idx == `RMC_IDX_PER1) begin
      rd_byte = per_reg[1];
    end else if (idx == `RMC_IDX_PER2) begin
      rd_byte = per_reg[2];
    end else if (idx == `RMC_IDX_RESA0) begin
      rd_byte = result_a[7:0];
    end else if (idx == `RMC_IDX_RESA1) begin
      rd_byte = result_a[15:8];
    end else if (idx == `RMC_IDX_RESA2) begin
      rd_byte = {4'h0, result_a[19:16]};
    end else if (idx == `RMC_IDX_RESB0) begin
      rd_byte = result_b[7:0];
    end else if (idx == `RMC_IDX_RESB1) begin
      rd_byte = result_b[15:8];
    end else if (idx == `RMC_IDX_RESB2) begin
      rd_byte = {4'h0, result_b[19:16]};
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // handshake outputs: accept each half while not yet held and no write response is pending
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_idx_reg  <= 10'h000;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[11:2];
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wbyte_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RMC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= idx_known(aw_idx_reg) ? `RMC_RESP_OKAY
                                            : `RMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, data registered one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte(s_axi_araddr[11:2])};
      s_axi_rresp  <= idx_known(s_axi_araddr[11:2]) ? `RMC_RESP_OKAY
                                                    : `RMC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sync control: software write, hardware self-clear of bit 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg <= `RMC_RST_ZERO;
    end else if (do_write && wlane_reg && aw_idx_reg == `RMC_IDX_SYNC) begin
      sync_reg <= wbyte_reg & `RMC_MASK_SYNC;
    end else if (div_fire && sync_reg[`RMC_SYNC_NEXT]) begin
      sync_reg[`RMC_SYNC_DIV] <= 1'b0;
    end
  end

  // plain read-write configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fd_reg     <= `RMC_RST_ZERO;
      coarse_reg <= `RMC_RST_ZERO;
      fup_lo_reg <= `RMC_RST_ZERO;
      fup_hi_reg <= `RMC_RST_ZERO;
      flo_lo_reg <= `RMC_RST_ZERO;
      flo_hi_reg <= `RMC_RST_ZERO;
      ser_reg    <= `RMC_RST_SER;
      mon_reg    <= `RMC_RST_ZERO;
    end else if (do_write && wlane_reg) begin
      // masks drop open bits on write
      if (aw_idx_reg == `RMC_IDX_FD) begin
        fd_reg <= wbyte_reg & `RMC_MASK_FD;
      end else if (aw_idx_reg == `RMC_IDX_COARSE) begin
        coarse_reg <= wbyte_reg & `RMC_MASK_COARSE;
      end else if (aw_idx_reg == `RMC_IDX_FUP_LO) begin
        fup_lo_reg <= wbyte_reg;
      end else if (aw_idx_reg == `RMC_IDX_FUP_HI) begin
        fup_hi_reg <= wbyte_reg & `RMC_MASK_FHI;
      end else if (aw_idx_reg == `RMC_IDX_FLO_LO) begin
        flo_lo_reg <= wbyte_reg;
      end else if (aw_idx_reg == `RMC_IDX_FLO_HI) begin
        flo_hi_reg <= wbyte_reg & `RMC_MASK_FHI;
      end else if (aw_idx_reg == `RMC_IDX_SER) begin
        ser_reg <= wbyte_reg & `RMC_MASK_SER;
      end else if (aw_idx_reg == `RMC_IDX_MON) begin
        mon_reg <= wbyte_reg & `RMC_MASK_MON;
      end
    end
  end

  // period bytes, one per index, lsb first
  for (genvar i = 0; i < 3; i++) begin : g_per
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        per_reg[i] <= (i == 0) ? `RMC_RST_PER0 : `RMC_RST_ZERO;
      end else if (do_write && wlane_reg
                   && aw_idx_reg == `RMC_IDX_PER0 + 10'(i)) begin
        per_reg[i] <= wbyte_reg;
      end
    end
  end

  // sync pin synchroniser and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
      sync_ff3 <= 1'b0;
    end else begin
      sync_ff1 <= sync_pin;
      sync_ff2 <= sync_ff1;
      sync_ff3 <= sync_ff2;
    end
  end

  assign sync_edge = sync_ff2 && !sync_ff3;
  // divider gate needs master and divider enables
  assign div_fire  = sync_edge && sync_reg[`RMC_SYNC_MASTER]
                     && sync_reg[`RMC_SYNC_DIV];

  // gated sync pulses, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_sync_pulse <= 1'b0;
      div_sync_pulse <= 1'b0;
    end else begin
      mon_sync_pulse <= sync_edge && sync_reg[`RMC_SYNC_MASTER]
                        && sync_reg[`RMC_SYNC_MON];
      div_sync_pulse <= div_fire;
    end
  end

  // fine threshold comparators, zero-extended magnitude
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      precise_upper_flag <= 1'b0;
      precise_lower_flag <= 1'b0;
    end else begin
      precise_upper_flag <= THR_W'(sample_mag)
        > THR_W'({fup_hi_reg[4:0], fup_lo_reg});
      precise_lower_flag <= THR_W'(sample_mag)
        < THR_W'({flo_hi_reg[4:0], flo_lo_reg});
    end
  end

  // fast detect pins: select source channel and enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fd_pin_o  <= '0;
      fd_pin_oe <= '0;
    end else if (!fd_reg[0]) begin
      fd_pin_o  <= '0;
      fd_pin_oe <= '0;
    end else if (diff_interleave) begin
      // one channel off: repeat the live one
      fd_pin_o  <= chan_a_on ? fd_a_in : fd_b_in;
      fd_pin_oe <= {FD_W{chan_a_on || chan_b_on}};
    end else begin
      fd_pin_o  <= fd_a_in;
      fd_pin_oe <= {FD_W{1'b1}};
    end
  end

  // monitor serial clock, parked low when off or asleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_cnt_reg         <= 2'd0;
      monitor_serial_clock <= 1'b0;
    end else if (!ser_reg[0] || ser_reg[3:2] == 2'b00
                 || (ser_reg[1] && !mon_data_pending)) begin
      sclk_cnt_reg         <= 2'd0;
      monitor_serial_clock <= 1'b0;
    end else if (sclk_cnt_reg >= half_last(ser_reg[3:2])) begin
      sclk_cnt_reg         <= 2'd0;
      monitor_serial_clock <= !monitor_serial_clock;
    end else begin
      sclk_cnt_reg <= sclk_cnt_reg + 2'd1;
    end
  end

  // configuration fan-out to the datapath
  always_comb begin
    fd_cfg.mode       = fd_reg[3:1];
    fd_cfg.coarse     = coarse_reg[2:0];
    mon_cfg.enable    = mon_reg[0];
    mon_cfg.complex_en = mon_reg[7];
    mon_cfg.ms_sel    = mon_reg[3];
    mon_cfg.mode      = mon_reg[2:1];
    // period below 128 is accepted; software must avoid it
    mon_cfg.period    = {per_reg[2], per_reg[1], per_reg[0]};
    ser_cfg.rms_out_en  = ser_reg[6];
    ser_cfg.peak_out_en = ser_reg[5];
    ser_cfg.thr_out_en  = ser_reg[4];
    ser_cfg.clk_div     = ser_reg[3:2];
    ser_cfg.sleep       = ser_reg[1];
    ser_cfg.port_en     = ser_reg[0];
  end

endmodule // rmc_top

// File: dv/rmc_top_sva.sv
/* port checker of the receive monitor control bank.
   assumes one clock aclk with synchronous active-low reset aresetn. */
`timescale 1ns/10ps
module rmc_chk #(
  parameter int FD_W = 2  // fast detect pins
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 sync_pin,
  input wire logic                 mon_sync_pulse,
  input wire logic                 div_sync_pulse,
  input wire logic                 diff_interleave,
  input wire logic                 chan_a_on,
  input wire logic                 chan_b_on,
  input wire logic [FD_W-1:0]      fd_a_in,
  input wire logic [FD_W-1:0]      fd_b_in,
  input wire logic [FD_W-1:0]      fd_pin_o,
  input wire logic [FD_W-1:0]      fd_pin_oe,
  input wire rmc_pkg::rmc_ser_cfg_t ser_cfg,
  input wire logic                 monitor_serial_clock,
  input wire logic                 s_axi_rvalid,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready
);
  import rmc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic en2;  // serial clock running at divide 2
  logic en4;  // serial clock running at divide 4
  assign en2 = ser_cfg.port_en && !ser_cfg.sleep && ser_cfg.clk_div == 2'b01;
  assign en4 = ser_cfg.port_en && !ser_cfg.sleep && ser_cfg.clk_div == 2'b10;
  // a pulse needs a pin rise a few cycles before, and lasts one cycle
  chk_mon_sync_cause: assert property (mon_sync_pulse |->
    $past(sync_pin, 3) && !$past(sync_pin, 4) ##1 !mon_sync_pulse)
    else $error("monitor sync pulse without pin rise");
  chk_div_sync_cause: assert property (div_sync_pulse |->
    $past(sync_pin, 3) && !$past(sync_pin, 4) ##1 !div_sync_pulse)
    else $error("divider sync pulse without pin rise");
  chk_fd_both_off: assert property (diff_interleave && !chan_a_on && !chan_b_on
    |=> fd_pin_oe == '0) else $error("fast detect driven with both channels off");
  chk_fd_repeat_b: assert property (diff_interleave && !chan_a_on && chan_b_on
    |=> fd_pin_oe == '0 || fd_pin_o == $past(fd_b_in)) else $error("fast detect not channel b");
  chk_fd_direct_a: assert property (!diff_interleave
    |=> fd_pin_oe == '0 || fd_pin_o == $past(fd_a_in)) else $error("fast detect not channel a");
  chk_sclk_div_two: assert property (en2 ##1 en2
    |-> monitor_serial_clock != $past(monitor_serial_clock)) else $error("divide 2 wrong");
  chk_sclk_div_four: assert property (en4 ##1 en4 && $changed(monitor_serial_clock)
    |=> $stable(monitor_serial_clock)) else $error("divide 4 wrong");
  chk_sclk_park_low: assert property (ser_cfg.clk_div == 2'b00 [*2]
    |-> !monitor_serial_clock) else $error("serial clock not parked low");
  chk_rdata_open_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  cover property (div_sync_pulse);
  cover property (en4 && $changed(monitor_serial_clock));
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule // rmc_chk
bind rmc_top rmc_chk #(.FD_W(FD_W)) i_chk (.*);

// File: dv/tb.sv
/* self-checking bench of the receive monitor control bank.
   assumes rmc_top, its package and header, and the bound checker. */
`timescale 1ns/10ps
module tb;
  import rmc_pkg::*;
  logic aclk, aresetn, sync_pin, mon_sync_pulse, div_sync_pulse, monitor_serial_clock;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fd_a_in, fd_b_in, fd_pin_o, fd_pin_oe;
  logic [9:0]  sample_mag;
  logic precise_upper_flag, precise_lower_flag, diff_interleave, chan_a_on, chan_b_on;
  logic mon_data_pending, sclk_q = 0;
  logic [13:0] dc_value_a, dc_value_b;
  logic [19:0] result_a, result_b;
  rmc_fd_cfg_t fd_cfg;
  rmc_mon_cfg_t mon_cfg;
  rmc_ser_cfg_t ser_cfg;
  int errors = 0, comparisons = 0, cycles = 0, n_mon = 0, n_div = 0, n_clk = 0;
  logic [31:0] seed = 32'h4a;  // xorshift state
  // writable registers, their masks and reset values
  logic [9:0] ridx [12] = '{10'h100, 10'h104, 10'h105, 10'h106, 10'h107, 10'h108, 10'h109,
                            10'h111, 10'h112, 10'h113, 10'h114, 10'h115};
  logic [7:0] rmsk [12] = '{8'h87, 8'h0f, 8'h07, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'h7f, 8'h8f,
                            8'hff, 8'hff, 8'hff};
  logic [7:0] rrst [12] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h04, 8'h0, 8'h40,
                            8'h0, 8'h0};
  logic [7:0] syv [8] = '{8'h81, 8'h80, 8'h03, 8'h02, 8'h07, 8'h87, 8'h05, 8'h86};
  logic [8:0] scv [7] = '{9'h005, 9'h009, 9'h00d, 9'h001, 9'h004, 9'h007, 9'h107};
  int scx [7] = '{32, 16, 8, 0, 0, 0, 32};  // expected toggles in 32 cycles
  rmc_top i_dut (.*);
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  // pulse and toggle counters, hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    n_mon <= n_mon + int'(mon_sync_pulse);
    n_div <= n_div + int'(div_sync_pulse);
    n_clk <= n_clk + int'(monitor_serial_clock !== sclk_q);
    sclk_q <= monitor_serial_clock;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one write, both halves offered together, answer taken after a random stall
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic st,
                    input logic [1:0] er);
    logic a, w;
    a = 0;
    w = 0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= (xs() & 32'hffffff00) | {24'h0, d};
    s_axi_wstrb <= {3'b0, st};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    repeat (xs() % 3) @(posedge aclk);
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er, "bresp");
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  // one read, compared with the expected byte and response
  task automatic rd(input logic [9:0] idx, input logic [7:0] ex, input logic [1:0] er);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    repeat (xs() % 3) @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, {24'h0, ex}, "rdata");
    check(s_axi_rresp, er, "rresp");
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  initial begin
    logic [31:0] v;
    logic [12:0] up, lo;
    logic [9:0]  m;
    logic [7:0]  wv [12];
    logic [79:0] ro;
    logic        oe;
    int          c0, c1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, sample_mag} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sync_pin, diff_interleave, chan_a_on, chan_b_on, mon_data_pending, fd_a_in, fd_b_in} = '0;
    {dc_value_a, dc_value_b, result_a, result_b} = '0;
    aresetn = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    v = xs();
    {dc_value_a, dc_value_b} <= v[27:0];
    v = xs();
    result_a <= v[19:0];
    v = xs();
    result_b <= v[19:0];
    for (int i = 0; i < 12; i++) rd(ridx[i], rrst[i], 2'b00);
    check(mon_cfg.period, 32'h40, "period reset");
    check(ser_cfg.clk_div, 32'h1, "divide reset");
    // random fields, masked read back, ignored write without strobe
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 12; i++) begin
        v = xs();
        if (i == 1) v[3:1] = r[2:0];
        if (i == 8) v[2:1] = r[1:0];
        if (i == 9) v[7] = 1'b1;
        wv[i] = v[7:0];
        wr(ridx[i], v[7:0], 1'b1, 2'b00);
        wr(ridx[i], ~v[7:0], 1'b0, 2'b00);
        rd(ridx[i], v[7:0] & rmsk[i], 2'b00);
      end
      check(fd_cfg, {wv[1][3:1], wv[2][2:0]}, "fd cfg");
      check(mon_cfg.period, {wv[11], wv[10], wv[9]}, "period");
      check(mon_cfg[28:24], {wv[8][0], wv[8][7], wv[8][3:1]}, "monitor ctl");
      check(mon_cfg.ms_sel, wv[8][3], "power select");
    end
    // read-only words ignore writes; unmapped places answer with an error
    ro = {4'h0, result_b, 4'h0, result_a, 2'b0, dc_value_b, 2'b0, dc_value_a};
    for (int i = 0; i < 10; i++) wr((i < 4) ? 10'h10d + i : 10'h112 + i, 8'hff, 1'b1, 2'b00);
    for (int i = 0; i < 10; i++) rd((i < 4) ? 10'h10d + i : 10'h112 + i, ro[8*i +: 8], 2'b00);
    wr(10'h101, 8'h5a, 1'b1, 2'b10);
    rd(10'h101, 8'h0, 2'b10);
    rd(10'h11c, 8'h0, 2'b10);
    // fine thresholds at and next to their boundaries
    for (int k = 0; k < 12; k++) begin
      v = xs();
      up = (k == 0) ? 13'h1fff : {3'b0, v[9:0]};
      lo = (k == 1) ? 13'h0 : {3'b0, v[19:10]};
      wr(10'h106, up[7:0], 1'b1, 2'b00);
      wr(10'h107, {3'b0, up[12:8]}, 1'b1, 2'b00);
      wr(10'h108, lo[7:0], 1'b1, 2'b00);
      wr(10'h109, {3'b0, lo[12:8]}, 1'b1, 2'b00);
      for (int j = 0; j < 4; j++) begin
        m = (j == 0) ? up[9:0] : (j == 1) ? up[9:0] + 10'h1 : (j == 2) ? lo[9:0] : lo[9:0] - 10'h1;
        sample_mag <= m;
        @(posedge aclk);
        @(posedge aclk);
        check(precise_upper_flag, {3'b0, m} > up, "upper flag");
        check(precise_lower_flag, {3'b0, m} < lo, "lower flag");
      end
    end
    // fast detect enable, interleave and channel states
    for (int k = 0; k < 24; k++) begin
      v = xs();
      if (k % 8 == 0) wr(10'h104, {4'h0, v[10:8], k[3]}, 1'b1, 2'b00);
      {diff_interleave, chan_a_on, chan_b_on, fd_a_in, fd_b_in} <= v[6:0];
      @(posedge aclk);
      @(posedge aclk);
      oe = k[3] && !(v[6] && !v[5] && !v[4]);
      check(fd_pin_oe, {2{oe}}, "fd enable");
      if (oe) check(fd_pin_o, (v[6] && !v[5]) ? v[1:0] : v[3:2], "fd data");
    end
    // sync gating, two pin pulses per setting
    foreach (syv[i]) begin
      wr(10'h100, syv[i], 1'b1, 2'b00);
      c0 = n_mon;
      c1 = n_div;
      repeat (2) begin
        sync_pin <= 1;
        repeat (6) @(posedge aclk);
        sync_pin <= 0;
        repeat (6) @(posedge aclk);
      end
      check(n_mon - c0, (syv[i][7] && syv[i][0]) ? 2 : 0, "monitor sync");
      check(n_div - c1, (syv[i][1] && syv[i][0]) ? (syv[i][2] ? 1 : 2) : 0, "divider sync");
      rd(10'h100, syv[i] & ((syv[i][2:0] == 3'b111) ? 8'h85 : 8'h87), 2'b00);
    end
    // serial clock ratios, sleep and enable
    foreach (scv[i]) begin
      mon_data_pending <= scv[i][8];
      wr(10'h111, scv[i][7:0], 1'b1, 2'b00);
      check(ser_cfg, scv[i][6:0], "serial cfg");
      c0 = n_clk;
      repeat (32) @(posedge aclk);
      check((n_clk - c0) inside {[scx[i] - 1 : scx[i] + 1]}, 1, "serial toggles");
    end
    // second reset in mid-run
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(10'h113, 8'h40, 2'b00);
    close_out();
  end
endmodule // tb
